//--- cbs_pkg.sv
// constants, field positions, reset values and states of the can bit-sync and message-map core
// assumes one clock domain and byte-wide special-function and message-ram access
// ============================================================
// Overview of operation
// - idle bus falling edge causes hard sync
// - hard sync: edge quantum becomes sync segment
// - later segments sized by timing registers
// - recessive-to-dominant edge causes soft resync
// - large phase error: shift by jump width
// - small phase error: edge quantum becomes sync
// - transmitter never resyncs to other edges
// - engine fetches transmit buffer from ram
// - engine matches received id, stores slot
// - cpu and engine share ram, arbitrated
// - registers hold documented reset values
// - bit access on control and rewrite register
// - ram in 16-byte slots, tx then rx
// - rx slots 0 and 2 double as masks
// - slot offsets added to selected ram base
// - ram contents undefined until written
// - jump width 1..4, not above phase 2
// - bit 3..25 quanta, quantum one clock minimum
package cbs_pkg;
    // ============================================================
    // register indices
    localparam int NUM_SFR = 12;
    localparam logic [3:0] SFR_CAN_CONTROL = 4'h0;
    localparam logic [3:0] SFR_TRANSMIT_CONTROL = 4'h1;
    localparam logic [3:0] SFR_RECEIVE_MESSAGE_STATUS = 4'h2;
    localparam logic [3:0] SFR_BUFFER_REWRITE_CONTROL = 4'h3;
    localparam logic [3:0] SFR_BUS_ERROR_STATUS = 4'h4;
    localparam logic [3:0] SFR_TX_ERROR_COUNT = 4'h5;
    localparam logic [3:0] SFR_RX_ERROR_COUNT = 4'h6;
    localparam logic [3:0] SFR_MESSAGE_COUNT_CONFIG = 4'h7;
    localparam logic [3:0] SFR_BIT_RATE_PRESCALER = 4'h8;
    localparam logic [3:0] SFR_BIT_TIMING_CTRL0 = 4'h9;
    localparam logic [3:0] SFR_BIT_TIMING_CTRL1 = 4'hA;
    localparam logic [3:0] SFR_ACCEPTANCE_MASK_CTRL = 4'hB;
    // ============================================================
    // reset values
    localparam logic [7:0] RST_CAN_CONTROL = 8'h01;
    localparam logic [7:0] RST_MESSAGE_COUNT_CONFIG = 8'hC0;
    localparam logic [7:0] RST_BIT_TIMING_CTRL0 = 8'h18;
    localparam logic [7:0] RST_BIT_TIMING_CTRL1 = 8'h0E;
    localparam logic [7:0] RST_ZERO = 8'h00;
    // ============================================================
    // field positions
    localparam int CTL_INIT = 0;
    localparam int CTL_SLEEP = 2;
    localparam int CTL_FRAME_START_ENABLE = 4;
    localparam int BUFFER_REWRITE_CONTROL_REWRITE_ENABLE = 7;
    localparam int MESSAGE_COUNT_CONFIG_BASE_LSB = 6;
    localparam int T0_PHASE2_LSB = 3;
    localparam int T0_SJW_LSB = 6;
    localparam int T1_TSEG1_LSB = 0;
    localparam int ES_OVERRUN = 0;
    localparam int MC_MASK0_EN = 0;
    localparam int MC_MASK1_EN = 1;
    localparam int RMS_VALID = 7;
    // ============================================================
    // message ram map
    localparam logic [4:0] SLOT_TX0 = 5'h00;
    localparam logic [4:0] SLOT_RX0 = 5'h02;
    localparam logic [4:0] SLOT_MASK1 = 5'h04;
    localparam logic [4:0] SLOT_RX_LAST = 5'h11;
    localparam logic [3:0] OFS_ID = 4'h2;
    localparam logic [3:0] OFS_DATA = 4'h8;
    localparam logic [3:0] OFS_LAST = 4'hF;
    localparam logic [3:0] MAX_DATA = 4'h8;
    // ============================================================
    // timing
    localparam logic [3:0] IDLE_BITS = 4'hB;
    localparam int FIFO_DEPTH = 4;
    // ============================================================
    // memory engine states
    typedef enum logic [1:0]
    {
        ENG_IDLE = 2'b00,
        ENG_TX = 2'b01,
        ENG_SCAN = 2'b10,
        ENG_STORE = 2'b11
    } cbs_eng_type;
endpackage

//--- cbs_can_core.sv
// fifo plus can bit timing, special-function registers and message-ram engine
// assumes a byte-wide ram with one-cycle read latency and a transceiver on the pins
`timescale 1ns/10ps
// ============================================================
// fifo
module cbs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    wire push = in_valid_in && in_ready_out;
    wire pop = out_valid_out && out_ready_in;
    assign in_ready_out = count != (AW+1)'(DEPTH);
    assign out_valid_out = count != '0;
    assign out_data_out = mem[rd_ptr];
    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop)
            begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
    always_ff @(posedge ref_clk_in)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_data_in;
        end
    end
endmodule
// ============================================================
// core
module cbs_can_core (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic [3:0] sfr_idx_in,
    input wire logic sfr_wr_in,
    input wire logic [7:0] sfr_wdata_in,
    input wire logic sfr_bit_wr_in,
    input wire logic [2:0] sfr_bit_in,
    input wire logic sfr_bit_val_in,
    input wire logic sfr_rd_in,
    output logic [7:0] sfr_rdata_out,
    input wire logic cpu_ram_req_in,
    input wire logic cpu_ram_wr_in,
    input wire logic [10:0] cpu_ram_addr_in,
    input wire logic [7:0] cpu_ram_wdata_in,
    output logic cpu_ram_gnt_out,
    output logic [7:0] cpu_ram_rdata_out,
    output logic [10:0] ram_addr_out,
    output logic ram_rd_out,
    output logic ram_wr_out,
    output logic [7:0] ram_wdata_out,
    input wire logic [7:0] ram_rdata_in,
    output logic bus_tx_pin_out,
    input wire logic bus_rx_pin_in
);
    import cbs_pkg::*;
    // ============================================================
    // registers
    logic [7:0] can_control;
    logic [7:0] transmit_control;
    logic [7:0] receive_message_status;
    logic [7:0] buffer_rewrite_control;
    logic [7:0] bus_error_status;
    logic [7:0] tx_error_count;
    logic [7:0] rx_error_count;
    logic [7:0] message_count_config;
    logic [7:0] bit_rate_prescaler;
    logic [7:0] bit_timing_ctrl0;
    logic [7:0] bit_timing_ctrl1;
    logic [7:0] acceptance_mask_ctrl;
    logic [7:0] sfr_view [NUM_SFR];
    assign sfr_view[SFR_CAN_CONTROL] = can_control;
    assign sfr_view[SFR_TRANSMIT_CONTROL] = transmit_control;
    assign sfr_view[SFR_RECEIVE_MESSAGE_STATUS] = receive_message_status;
    assign sfr_view[SFR_BUFFER_REWRITE_CONTROL] = buffer_rewrite_control;
    assign sfr_view[SFR_BUS_ERROR_STATUS] = bus_error_status;
    assign sfr_view[SFR_TX_ERROR_COUNT] = tx_error_count;
    assign sfr_view[SFR_RX_ERROR_COUNT] = rx_error_count;
    assign sfr_view[SFR_MESSAGE_COUNT_CONFIG] = message_count_config;
    assign sfr_view[SFR_BIT_RATE_PRESCALER] = bit_rate_prescaler;
    assign sfr_view[SFR_BIT_TIMING_CTRL0] = bit_timing_ctrl0;
    assign sfr_view[SFR_BIT_TIMING_CTRL1] = bit_timing_ctrl1;
    assign sfr_view[SFR_ACCEPTANCE_MASK_CTRL] = acceptance_mask_ctrl;
    wire idx_ok = sfr_idx_in < 4'(NUM_SFR);
    wire [7:0] rd_sel = idx_ok ? sfr_view[sfr_idx_in] : RST_ZERO;
    wire [7:0] bit_sel = 8'h01 << sfr_bit_in;
    wire bw_ctl = sfr_bit_wr_in && sfr_idx_in == SFR_CAN_CONTROL;
    wire bw_buffer_rewrite_control = sfr_bit_wr_in && sfr_idx_in == SFR_BUFFER_REWRITE_CONTROL;
    wire [7:0] next_can_control = sfr_bit_val_in ? can_control | bit_sel : can_control & ~bit_sel;
    wire [7:0] next_buffer_rewrite_control = sfr_bit_val_in ? buffer_rewrite_control | bit_sel
                                           : buffer_rewrite_control & ~bit_sel;
    wire bwr = sfr_wr_in && !sfr_bit_wr_in;
    wire running = !can_control[CTL_INIT] && !can_control[CTL_SLEEP];
    // ============================================================
    // quantum and segment decode
    wire [4:0] tseg1 = 5'(bit_timing_ctrl1[T1_TSEG1_LSB +: 4]) + 5'h01;
    wire [3:0] phase2 = 4'(bit_timing_ctrl0[T0_PHASE2_LSB +: 3]) + 4'h1;
    wire [3:0] sjw_raw = 4'(bit_timing_ctrl0[T0_SJW_LSB +: 2]) + 4'h1;
    wire [3:0] resync_jump_width = (sjw_raw > phase2) ? phase2 : sjw_raw;
    wire [5:0] last_q = 6'(tseg1) + 6'(phase2);
    logic [7:0] brp_cnt;
    logic [5:0] q;
    logic rx_prev;
    wire tq_en = running && brp_cnt == bit_rate_prescaler;
    wire edge_fall = tq_en && rx_prev && !bus_rx_pin_in;
    logic idle;
    logic tx_active;
    wire hard_sync = edge_fall && idle;
    wire soft_sync = edge_fall && !idle && !tx_active && q != 6'h00;
    wire early = q <= 6'(tseg1);
    wire [5:0] err = early ? q : last_q + 6'h01 - q;
    wire small_err = err <= 6'(resync_jump_width);
    wire [5:0] q_late = q + 6'(resync_jump_width);
    wire [5:0] q_adj = early ? q - 6'(resync_jump_width) : ((q_late > last_q) ? last_q : q_late);
    wire [5:0] q_eff = hard_sync ? 6'h00
                     : !soft_sync ? q
                     : small_err ? 6'h00
                     : q_adj;
    wire [5:0] next_q = (q_eff == last_q) ? 6'h00 : q_eff + 6'h01;
    wire sample_en = tq_en && q == 6'(tseg1);
    wire bit_start = tq_en && next_q == 6'h00;
    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            brp_cnt <= 8'h00;
            q <= 6'h00;
            rx_prev <= 1'b1;
        end
        else if (!running)
        begin
            brp_cnt <= 8'h00;
            q <= 6'h00;
            rx_prev <= 1'b1;
        end
        else
        begin
            brp_cnt <= tq_en ? 8'h00 : brp_cnt + 8'h01;
            if (tq_en)
            begin
                q <= next_q;
                rx_prev <= bus_rx_pin_in;
            end
        end
    end
    // ============================================================
    // idle detection and receive shifter
    logic [3:0] idle_cnt;
    logic [7:0] rx_sh;
    logic [2:0] rx_bits;
    logic [3:0] rx_nbytes;
    logic [7:0] rx_byte;
    logic rx_first;
    logic rx_pend;
    logic rx_take;
    logic rx_frame;
    wire rx_shift = sample_en && rx_frame && !idle && !tx_active;
    wire rx_done = rx_shift && rx_bits == 3'h7;
    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            idle_cnt <= 4'h0;
            idle <= 1'b0;
            rx_sh <= 8'h00;
            rx_bits <= 3'h0;
            rx_nbytes <= 4'h0;
            rx_byte <= 8'h00;
            rx_first <= 1'b0;
            rx_pend <= 1'b0;
            rx_frame <= 1'b0;
        end
        else
        begin
            if (sample_en)
            begin
                idle_cnt <= bus_rx_pin_in ? ((idle_cnt == IDLE_BITS) ? idle_cnt
                                             : idle_cnt + 4'h1) : 4'h0;
                idle <= bus_rx_pin_in && (idle || idle_cnt + 4'h1 >= IDLE_BITS);
            end
            if (idle)
            begin
                rx_bits <= 3'h0;
                rx_nbytes <= 4'h0;
            end
            else if (rx_shift)
            begin
                rx_sh <= {rx_sh[6:0], bus_rx_pin_in};
                rx_bits <= rx_bits + 3'h1;
                if (rx_done)
                begin
                    rx_byte <= {rx_sh[6:0], bus_rx_pin_in};
                    rx_first <= rx_nbytes == 4'h0;
                    rx_nbytes <= (rx_nbytes == OFS_LAST) ? rx_nbytes : rx_nbytes + 4'h1;
                end
            end
            rx_pend <= rx_done || (rx_pend && !rx_take);
            if (hard_sync || tx_active)
            begin
                rx_frame <= !tx_active;
            end
        end
    end
    // ============================================================
    // transmit path: fifo to serialiser
    logic fifo_push;
    logic fifo_in_ready;
    logic fifo_valid;
    logic [7:0] fifo_data;
    logic [7:0] tx_sh;
    logic [2:0] tx_bits;
    logic tx_pin;
    wire tx_load = bit_start && tx_bits == 3'h0 && fifo_valid && (idle || tx_active);
    cbs_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) tx_fifo (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .in_valid_in(fifo_push),
        .in_ready_out(fifo_in_ready),
        .in_data_in(ram_rdata_in),
        .out_valid_out(fifo_valid),
        .out_ready_in(tx_load),
        .out_data_out(fifo_data)
    );
    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            tx_sh <= 8'h00;
            tx_bits <= 3'h0;
            tx_pin <= 1'b1;
            tx_active <= 1'b0;
        end
        else if (!running)
        begin
            tx_bits <= 3'h0;
            tx_pin <= 1'b1;
            tx_active <= 1'b0;
        end
        else if (bit_start)
        begin
            if (tx_bits != 3'h0)
            begin
                tx_pin <= tx_sh[7];
                tx_sh <= {tx_sh[6:0], 1'b0};
                tx_bits <= tx_bits - 3'h1;
            end
            else if (tx_load)
            begin
                tx_pin <= fifo_data[7];
                tx_sh <= {fifo_data[6:0], 1'b0};
                tx_bits <= 3'h7;
                tx_active <= 1'b1;
            end
            else
            begin
                tx_pin <= 1'b1;
                tx_active <= 1'b0;
            end
        end
    end
    assign bus_tx_pin_out = tx_pin;
    // ============================================================
    // message ram engine
    cbs_eng_type state;
    logic [4:0] e_slot;
    logic [3:0] e_ofs;
    logic rd_pend;
    logic [4:0] match_slot;
    logic matched;
    logic [7:0] rx_id;
    logic [7:0] id_mask;
    logic [3:0] data_idx;
    logic [7:0] store_byte;
    logic txrq_clr;
    logic [1:0] tx_buf;
    logic cpu_rd_pend;
    wire eng_rd = (state == ENG_TX && fifo_in_ready && !rd_pend)
               || (state == ENG_SCAN && !rd_pend);
    wire eng_wr = state == ENG_STORE;
    wire eng_go = (eng_rd || eng_wr) && !cpu_ram_req_in;
    wire [2:0] base_sel = {1'b0, message_count_config[MESSAGE_COUNT_CONFIG_BASE_LSB +: 2]};
    wire [4:0] ram_slot = eng_wr ? match_slot : e_slot;
    wire [3:0] ram_ofs = eng_wr ? OFS_DATA + data_idx : e_ofs;
    wire [10:0] eng_addr = {base_sel[1:0], ram_slot, ram_ofs};
    assign cpu_ram_gnt_out = cpu_ram_req_in;
    assign ram_addr_out = cpu_ram_req_in ? cpu_ram_addr_in : eng_addr;
    assign ram_rd_out = cpu_ram_req_in ? !cpu_ram_wr_in : eng_go && eng_rd;
    assign ram_wr_out = cpu_ram_req_in ? cpu_ram_wr_in : eng_go && eng_wr;
    assign ram_wdata_out = cpu_ram_req_in ? cpu_ram_wdata_in : store_byte;
    assign fifo_push = rd_pend && (state == ENG_TX || txrq_clr);
    wire is_mask0 = e_slot == SLOT_RX0 && acceptance_mask_ctrl[MC_MASK0_EN];
    wire is_mask1 = e_slot == SLOT_MASK1 && acceptance_mask_ctrl[MC_MASK1_EN];
    wire id_hit = ((ram_rdata_in ^ rx_id) & ~id_mask) == 8'h00;
    wire [4:0] rx_index = e_slot - SLOT_RX0;
    wire [1:0] txrq = transmit_control[1:0];
    assign rx_take = state == ENG_IDLE && rx_pend;
    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state <= ENG_IDLE;
            e_slot <= 5'h00;
            e_ofs <= 4'h0;
            rd_pend <= 1'b0;
            match_slot <= 5'h00;
            matched <= 1'b0;
            rx_id <= 8'h00;
            id_mask <= 8'h00;
            data_idx <= 4'h0;
            store_byte <= 8'h00;
            txrq_clr <= 1'b0;
            tx_buf <= 2'b00;
        end
        else
        begin
            rd_pend <= eng_go && eng_rd;
            txrq_clr <= 1'b0;
            case (state)
                ENG_IDLE:
                begin
                    if (rx_pend && rx_first)
                    begin
                        rx_id <= rx_byte;
                        id_mask <= 8'h00;
                        matched <= 1'b0;
                        e_slot <= SLOT_RX0;
                        e_ofs <= OFS_ID;
                        state <= ENG_SCAN;
                    end
                    else if (rx_pend)
                    begin
                        store_byte <= rx_byte;
                        if (matched && data_idx != MAX_DATA)
                        begin
                            state <= ENG_STORE;
                        end
                    end
                    else if (txrq != 2'b00 && !tx_active && !fifo_valid)
                    begin
                        tx_buf <= txrq[0] ? 2'b01 : 2'b10;
                        e_slot <= txrq[0] ? SLOT_TX0 : SLOT_TX0 + 5'h01;
                        e_ofs <= 4'h0;
                        state <= ENG_TX;
                    end
                end
                ENG_TX:
                begin
                    if (eng_go)
                    begin
                        e_ofs <= e_ofs + 4'h1;
                        if (e_ofs == OFS_LAST)
                        begin
                            txrq_clr <= 1'b1;
                            state <= ENG_IDLE;
                        end
                    end
                end
                ENG_SCAN:
                begin
                    if (rd_pend)
                    begin
                        if (is_mask0 || is_mask1)
                        begin
                            id_mask <= id_mask | ram_rdata_in;
                        end
                        else if (id_hit)
                        begin
                            matched <= 1'b1;
                            match_slot <= e_slot;
                            data_idx <= 4'h0;
                        end
                        if ((id_hit && !is_mask0 && !is_mask1) || e_slot == SLOT_RX_LAST)
                        begin
                            state <= ENG_IDLE;
                        end
                        e_slot <= e_slot + 5'h01;
                    end
                end
                ENG_STORE:
                begin
                    if (eng_go)
                    begin
                        data_idx <= data_idx + 4'h1;
                        state <= ENG_IDLE;
                    end
                end
                default:
                begin
                    state <= ENG_IDLE;
                end
            endcase
        end
    end
    // ============================================================
    // register writes and reads
    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            can_control <= RST_CAN_CONTROL;
            transmit_control <= RST_ZERO;
            receive_message_status <= RST_ZERO;
            buffer_rewrite_control <= RST_ZERO;
            bus_error_status <= RST_ZERO;
            tx_error_count <= RST_ZERO;
            rx_error_count <= RST_ZERO;
            message_count_config <= RST_MESSAGE_COUNT_CONFIG;
            bit_rate_prescaler <= RST_ZERO;
            bit_timing_ctrl0 <= RST_BIT_TIMING_CTRL0;
            bit_timing_ctrl1 <= RST_BIT_TIMING_CTRL1;
            acceptance_mask_ctrl <= RST_ZERO;
            sfr_rdata_out <= RST_ZERO;
            cpu_ram_rdata_out <= RST_ZERO;
            cpu_rd_pend <= 1'b0;
        end
        else
        begin
            if (bw_ctl)
            begin
                can_control <= next_can_control;
            end
            else if (bwr && sfr_idx_in == SFR_CAN_CONTROL)
            begin
                can_control <= sfr_wdata_in;
            end
            if (bw_buffer_rewrite_control)
            begin
                buffer_rewrite_control <= next_buffer_rewrite_control;
            end
            else if (bwr && sfr_idx_in == SFR_BUFFER_REWRITE_CONTROL)
            begin
                buffer_rewrite_control <= sfr_wdata_in;
            end
            if (bwr && sfr_idx_in == SFR_TRANSMIT_CONTROL)
            begin
                transmit_control <= sfr_wdata_in;
            end
            else if (txrq_clr)
            begin
                transmit_control <= transmit_control & ~{6'h00, tx_buf};
            end
            if (bwr && sfr_idx_in == SFR_BIT_RATE_PRESCALER)
            begin
                bit_rate_prescaler <= sfr_wdata_in;
            end
            if (bwr && sfr_idx_in == SFR_BIT_TIMING_CTRL0)
            begin
                bit_timing_ctrl0 <= sfr_wdata_in;
            end
            if (bwr && sfr_idx_in == SFR_BIT_TIMING_CTRL1)
            begin
                bit_timing_ctrl1 <= sfr_wdata_in;
            end
            if (bwr && sfr_idx_in == SFR_ACCEPTANCE_MASK_CTRL)
            begin
                acceptance_mask_ctrl <= sfr_wdata_in;
            end
            if (rx_done && rx_pend && !rx_take)
            begin
                bus_error_status[ES_OVERRUN] <= 1'b1;
            end
            else if (bwr && sfr_idx_in == SFR_BUS_ERROR_STATUS && sfr_wdata_in[ES_OVERRUN])
            begin
                bus_error_status[ES_OVERRUN] <= 1'b0;
            end
            if (state == ENG_SCAN && rd_pend && id_hit && !is_mask0 && !is_mask1)
            begin
                receive_message_status <= {1'b1, 3'h0, rx_index[3:0]};
            end
            if (sfr_rd_in)
            begin
                sfr_rdata_out <= rd_sel;
            end
            cpu_rd_pend <= cpu_ram_req_in && !cpu_ram_wr_in;
            if (cpu_rd_pend)
            begin
                cpu_ram_rdata_out <= ram_rdata_in;
            end
        end
    end
endmodule

//--- cbs_xcvr_model.sv
// bus transceiver model: wired-and of own transmit and other nodes
// assumes 1 is recessive on both lines
`timescale 1ns/10ps
module cbs_xcvr_model (
    input wire logic tx_in,
    input wire logic dom_in,
    output logic rx_out
);
    assign rx_out = tx_in & ~dom_in;
endmodule

//--- cbs_can_core_sva.sv
// port checker of the can core
// assumes a bind from the testbench top file
`timescale 1ns/10ps
module cbs_can_core_sva (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic [3:0] sfr_idx_in,
    input wire logic sfr_rd_in,
    input wire logic [7:0] sfr_rdata_out,
    input wire logic cpu_ram_req_in,
    input wire logic cpu_ram_wr_in,
    input wire logic [10:0] cpu_ram_addr_in,
    input wire logic cpu_ram_gnt_out,
    input wire logic [7:0] cpu_ram_rdata_out,
    input wire logic [10:0] ram_addr_out,
    input wire logic ram_rd_out,
    input wire logic ram_wr_out,
    input wire logic [7:0] ram_rdata_in,
    input wire logic bus_tx_pin_out
);
    wire eng = !cpu_ram_req_in && (ram_rd_out || ram_wr_out);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    a_gnt_req: assert property (cpu_ram_gnt_out == cpu_ram_req_in)
        else $error("grant differs");
    a_cpu_addr: assert property (cpu_ram_req_in |-> ram_addr_out == cpu_ram_addr_in)
        else $error("cpu address");
    a_cpu_rd: assert property (cpu_ram_req_in && !cpu_ram_wr_in |-> ram_rd_out && !ram_wr_out)
        else $error("cpu read");
    a_cpu_wr: assert property (cpu_ram_req_in && cpu_ram_wr_in |-> ram_wr_out && !ram_rd_out)
        else $error("cpu write");
    a_rd_data: assert property (cpu_ram_req_in && !cpu_ram_wr_in |-> ##2
        cpu_ram_rdata_out == $past(ram_rdata_in)) else $error("cpu data");
    a_eng_base: assert property (eng |-> ram_addr_out[10:9] == 2'h3)
        else $error("ram base");
    a_eng_slot: assert property (eng |-> ram_addr_out[8:4] <= 5'h11)
        else $error("slot range");
    a_unmapped: assert property (sfr_rd_in && sfr_idx_in > 4'hB |=> sfr_rdata_out == 8'h00)
        else $error("unmapped read");
    c_cpu_rd: cover property (cpu_ram_req_in && !cpu_ram_wr_in);
    c_eng_rd: cover property (eng);
    c_tx_dom: cover property ($fell(bus_tx_pin_out));
endmodule

//--- testbench.sv
// testbench: registers, shared ram and transmit line
// assumes a byte ram model here and the transceiver model
`timescale 1ns/10ps
module testbench;
    import cbs_pkg::*;
    logic ref_clk_in = '0, rst_n_in = '0, sfr_wr_in = '0, sfr_bit_wr_in = '0, dom = '0;
    logic sfr_bit_val_in = '0, sfr_rd_in = '0, cpu_ram_req_in = '0, cpu_ram_wr_in = '0;
    logic [3:0] sfr_idx_in = '0;
    logic [2:0] sfr_bit_in = '0;
    logic [7:0] sfr_wdata_in = '0, cpu_ram_wdata_in = '0, ram_rdata_in = '0;
    logic [7:0] sfr_rdata_out, cpu_ram_rdata_out, ram_wdata_out, mem [2048];
    logic [10:0] cpu_ram_addr_in = '0, ram_addr_out;
    logic cpu_ram_gnt_out, ram_rd_out, ram_wr_out, bus_tx_pin_out, bus_rx_pin_in;
    int failures = 0, n_tests = 0;
    cbs_can_core u_cbs_can_core (.*);
    cbs_xcvr_model u_cbs_xcvr_model (.tx_in(bus_tx_pin_out), .dom_in(dom),
        .rx_out(bus_rx_pin_in));
    always #4 ref_clk_in = ~ref_clk_in;
    always @(posedge ref_clk_in)
    begin
        if (ram_wr_out) mem[ram_addr_out] <= ram_wdata_out;
        ram_rdata_in <= mem[ram_addr_out];
    end
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task wreg(input logic [3:0] i, input logic [7:0] d, input logic b);
        sfr_idx_in = i;
        sfr_wdata_in = d;
        sfr_bit_in = d[2:0];
        sfr_bit_val_in = d[7];
        sfr_wr_in = !b;
        sfr_bit_wr_in = b;
        @(posedge ref_clk_in) #1 sfr_wr_in = 0;
        sfr_bit_wr_in = 0;
        @(posedge ref_clk_in) #1;
    endtask
    task rreg(input logic [3:0] i, input logic [7:0] e);
        sfr_idx_in = i;
        sfr_rd_in = 1;
        @(posedge ref_clk_in) #1 sfr_rd_in = 0;
        chk(sfr_rdata_out, e);
        @(posedge ref_clk_in) #1;
    endtask
    task ram(input logic w, input logic [10:0] a, input logic [7:0] d);
        cpu_ram_req_in = 1;
        cpu_ram_wr_in = w;
        cpu_ram_addr_in = a;
        cpu_ram_wdata_in = d;
        @(posedge ref_clk_in) #1 cpu_ram_req_in = 0;
        repeat (2) @(posedge ref_clk_in) #1;
        if (!w) chk(cpu_ram_rdata_out, d);
    endtask
    task t_regs;
        for (int i = 0; i < 13; i++)
            rreg(4'(i), i==0 ? 8'h01 : i==7 ? 8'hC0 : i==9 ? 8'h18 : i==10 ? 8'h0E : 8'h00);
        wreg(4'h7, 8'h00, 0);
        rreg(4'h7, 8'hC0);
        wreg(4'h0, 8'h84, 1);
        rreg(4'h0, 8'h11);
        wreg(4'h3, 8'h87, 1);
        rreg(4'h3, 8'h80);
        wreg(4'h8, 8'h81, 1);
        rreg(4'h8, 8'h00);
        ram(1, 11'h625, 8'h3C);
        ram(0, 11'h625, 8'h3C);
        $display("t_regs done");
    endtask
    task t_tx;
        logic [7:0] got;
        int w;
        for (int k = 0; k < 16; k++)
            ram(1, 11'h600 + 11'(k), 8'h5A);
        wreg(4'h0, 8'h00, 0);
        wreg(4'h1, 8'h01, 0);
        w = 0;
        while (bus_tx_pin_out !== 1'b0 && w < 3000) @(negedge ref_clk_in) w++;
        repeat (10) @(negedge ref_clk_in);
        for (int k = 0; k < 8; k++)
        begin
            got[7 - k] = bus_tx_pin_out;
            repeat (20) @(negedge ref_clk_in);
        end
        chk(got, 8'h5A);
        $display("t_tx done");
    endtask
    task t_rx;
        logic [7:0] id;
        id = 8'hA5;
        ram(1, 11'h622, id);
        repeat (3000) @(posedge ref_clk_in) #1;
        dom = 1;
        for (int k = 0; k < 9; k++)
        begin
            repeat (20) @(posedge ref_clk_in) #1;
            dom = k < 8 && !id[7 - k];
        end
        repeat (40) @(posedge ref_clk_in) #1;
        rreg(4'h2, 8'h80);
        $display("t_rx done");
    endtask
    task end_sim;
        $display("tests %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        #100000;
        failures++;
        end_sim;
    end
    initial
    begin
        repeat (3) @(posedge ref_clk_in);
        #1 rst_n_in = 1;
        t_regs;
        t_tx;
        t_rx;
        end_sim;
    end
endmodule
bind cbs_can_core cbs_can_core_sva u_cbs_can_core_sva (.*);
